// file: rtl/lcd_bus_if.sv
// Purpose: Pins between host processor and LCD driver
// Assumes: Both ends run on one clock; each end drives its own data lines, host_d or dev_d
// Notes:   rd_e is read strobe (80) or enable (68); wr_rw is write strobe or direction
`default_nettype none

interface lcd_bus_if;
   logic hw_reset_n;
   logic cmd_data_select;
   logic rd_e;
   logic wr_rw;
   logic [7:0] host_d;
   logic host_d_oe;
   logic [7:0] dev_d;
   logic dev_d_oe;
   logic cs_n;
   logic sclk;
   logic sdi;

   modport host (output hw_reset_n, cmd_data_select, rd_e, wr_rw, host_d, host_d_oe,
      cs_n, sclk, sdi, input dev_d, dev_d_oe);
   modport device (input hw_reset_n, cmd_data_select, rd_e, wr_rw, host_d, host_d_oe,
      cs_n, sclk, sdi, output dev_d, dev_d_oe);
endinterface

`default_nettype wire

// file: rtl/lcd_cmd_cfg.svh
// Purpose: Command codes, limits and reset values of the LCD command decoder
// Assumes: Included by both bus ends
// Notes:   Opcodes with a selector in bit 0 are kept as their upper seven bits
`ifndef LCD_CMD_CFG_SVH
`define LCD_CMD_CFG_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define LCD_OP_DISP_ONOFF 7'h57
`define LCD_OP_OFF_LEVEL 7'h5F
`define LCD_OP_POLARITY 7'h53
`define LCD_OP_ALL_LIT 7'h52
`define LCD_OP_COM_DIR 7'h62
`define LCD_CMD_START_LINE 8'h8A
`define LCD_CMD_PAGE 8'hB1
`define LCD_CMD_COLUMN 8'h13
`define LCD_CMD_DISP_MODE 8'h66
`define LCD_CMD_SW_RESET 8'hE2

// ----------------------------------------------------------------------
// Limits, fields and reset values
// ----------------------------------------------------------------------
`define LCD_START_MAX_GRAY 9'h083
`define LCD_START_MAX_BIN 9'h107
`define LCD_PAGE_MAX 6'h20
`define LCD_COL_MAX 8'h9F
`define LCD_PAGE_W 6
`define LCD_MODE_GRAY 2'h0
`define LCD_MODE_BIN 2'h1
`define LCD_START_RST 9'h000
`define LCD_PAGE_RST 6'h00
`define LCD_COL_RST 8'h00
`define LCD_BITS_PER_BYTE 3'h7
`define LCD_HOST_DIV_DEF 4

`endif

// file: rtl/lcd_cmd_device.sv
// Purpose: Driver end: classifies bus cycles and executes display commands
// Assumes: All pins are asynchronous to clock and are synchronised here
// Notes:   Strobes must last at least four clocks to be seen
`include "lcd_cmd_cfg.svh"
`default_nettype none

module lcd_cmd_device (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Bus pins
   lcd_bus_if.device bus,
   // Static bus selection
   input wire lcd_cmd_pkg::bus_mode_t bus_mode,
   // Read data supplied by the display memory side
   input wire logic [7:0] rd_data,
   // Transfer report
   output logic xfer_valid_q,
   output lcd_cmd_pkg::xfer_kind_t xfer_kind_q,
   output logic [7:0] xfer_byte_q,
   // Settings
   output logic display_on_q,
   output logic off_level_mid_q,
   output logic reverse_q,
   output logic all_lit_q,
   output logic com_reverse_q,
   output logic [1:0] disp_mode_q,
   output logic [8:0] start_line_q,
   output logic [5:0] page_q,
   output logic [7:0] column_q,
   output lcd_cmd_pkg::drive_t drive_q,
   output logic rmw_clear_q
);

   typedef enum logic [2:0] {P_NONE, P_START_LO, P_START_HI, P_PAGE, P_COLUMN, P_MODE}
      pend_t;

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   localparam int SW = 15;
   logic [SW-1:0] meta_q, sync_q;
   logic act_prev_q, act_rd_q, sclk_prev_q;
   logic [2:0] bit_cnt_q;
   logic [6:0] shift_q;
   logic byte_stb, byte_dsel, strobe_act, strobe_read, hw_rst;
   logic [7:0] byte_val;
   pend_t pend_q;
   logic [7:0] start_lo_q;
   logic soft_rst;

   always_ff @(posedge clock) begin
      if (rst) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= {bus.hw_reset_n, bus.cmd_data_select, bus.rd_e, bus.wr_rw, bus.cs_n,
            bus.sclk, bus.sdi, bus.host_d};
         sync_q <= meta_q;
      end
   end

   wire s_rst_n = sync_q[14];
   wire s_dsel = sync_q[13];
   wire s_rd_e = sync_q[12];
   wire s_wr_rw = sync_q[11];
   wire s_cs_n = sync_q[10];
   wire s_sclk = sync_q[9];
   wire s_sdi = sync_q[8];
   wire [7:0] s_d = sync_q[7:0];

   // Pin reset stays active after rst until the synchroniser has filled with a high pin level
   assign hw_rst = rst | ~s_rst_n;

   // ----------------------------------------------------------------------
   // Parallel strobes
   // ----------------------------------------------------------------------
   always_comb begin
      if (bus_mode == lcd_cmd_pkg::BUS_68) begin
         strobe_act = s_rd_e;
         strobe_read = s_wr_rw;
      end else begin
         strobe_act = ~s_rd_e | ~s_wr_rw;
         strobe_read = ~s_rd_e;
      end
   end

   always_ff @(posedge clock) begin
      if (hw_rst) begin
         act_prev_q <= 1'b0;
         act_rd_q <= 1'b0;
         sclk_prev_q <= 1'b0;
      end else begin
         act_prev_q <= strobe_act;
         // Remembers a read strobe so that its trailing edge is never taken as a write
         act_rd_q <= strobe_act && strobe_read;
         sclk_prev_q <= s_sclk;
      end
   end

   // Read data is driven for as long as the read strobe stands
   always_ff @(posedge clock) begin
      if (hw_rst) begin
         bus.dev_d_oe <= 1'b0;
         bus.dev_d <= 8'h00;
      end else begin
         bus.dev_d_oe <= (bus_mode != lcd_cmd_pkg::BUS_SERIAL) && strobe_act && strobe_read;
         bus.dev_d <= rd_data;
      end
   end

   // ----------------------------------------------------------------------
   // Serial shifter
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (hw_rst || s_cs_n || bus_mode != lcd_cmd_pkg::BUS_SERIAL) begin
         bit_cnt_q <= 3'h0;
         shift_q <= 7'h00;
      end else if (s_sclk && !sclk_prev_q) begin
         bit_cnt_q <= bit_cnt_q + 3'h1;
         shift_q <= {shift_q[5:0], s_sdi};
      end
   end

   // ----------------------------------------------------------------------
   // Byte source; a parallel write byte is taken as the strobe ends, a serial one at the eighth clock rise
   // ----------------------------------------------------------------------
   always_comb begin
      byte_stb = 1'b0;
      byte_dsel = s_dsel;
      byte_val = s_d;
      if (bus_mode == lcd_cmd_pkg::BUS_SERIAL) begin
         byte_stb = !s_cs_n && s_sclk && !sclk_prev_q && bit_cnt_q == `LCD_BITS_PER_BYTE;
         byte_val = {shift_q, s_sdi};
      end else begin
         byte_stb = act_prev_q && !strobe_act && !act_rd_q;
      end
   end

   wire rd_start = bus_mode != lcd_cmd_pkg::BUS_SERIAL && strobe_act && !act_prev_q
      && strobe_read;

   // ----------------------------------------------------------------------
   // Transfer classification
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (hw_rst) begin
         xfer_valid_q <= 1'b0;
         xfer_kind_q <= lcd_cmd_pkg::XF_COMMAND;
         xfer_byte_q <= 8'h00;
      end else begin
         xfer_valid_q <= byte_stb | rd_start;
         if (rd_start) begin
            xfer_kind_q <= lcd_cmd_pkg::XF_DATA_READ;
            xfer_byte_q <= rd_data;
         end else if (byte_stb) begin
            xfer_byte_q <= byte_val;
            if (!byte_dsel)
               xfer_kind_q <= lcd_cmd_pkg::XF_COMMAND;
            else if (pend_q != P_NONE)
               xfer_kind_q <= lcd_cmd_pkg::XF_PARAM;
            else
               xfer_kind_q <= lcd_cmd_pkg::XF_DATA_WRITE;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Parameter sequencer
   // ----------------------------------------------------------------------
   wire cmd_stb = byte_stb && !byte_dsel;
   wire par_stb = byte_stb && byte_dsel;
   assign soft_rst = cmd_stb && byte_val == `LCD_CMD_SW_RESET;

   // A new command abandons any parameter still owed
   always_ff @(posedge clock) begin
      if (hw_rst) begin
         pend_q <= P_NONE;
      end else if (cmd_stb) begin
         unique case (byte_val)
            `LCD_CMD_START_LINE: pend_q <= P_START_LO;
            `LCD_CMD_PAGE: pend_q <= P_PAGE;
            `LCD_CMD_COLUMN: pend_q <= P_COLUMN;
            `LCD_CMD_DISP_MODE: pend_q <= P_MODE;
            default: pend_q <= P_NONE;
         endcase
      end else if (par_stb) begin
         if (pend_q == P_START_LO && disp_mode_q == `LCD_MODE_BIN)
            pend_q <= P_START_HI;
         else
            pend_q <= P_NONE;
      end
   end

   always_ff @(posedge clock) begin
      if (hw_rst)
         start_lo_q <= 8'h00;
      else if (par_stb && pend_q == P_START_LO)
         start_lo_q <= byte_val;
   end

   // ----------------------------------------------------------------------
   // Display settings; single-byte commands carry their choice in bit 0
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (hw_rst) begin
         display_on_q <= 1'b0;
         off_level_mid_q <= 1'b0;
         reverse_q <= 1'b0;
         all_lit_q <= 1'b0;
         com_reverse_q <= 1'b0;
      end else if (cmd_stb) begin
         unique case (byte_val[7:1])
            `LCD_OP_DISP_ONOFF: display_on_q <= byte_val[0];
            `LCD_OP_OFF_LEVEL: off_level_mid_q <= byte_val[0];
            `LCD_OP_POLARITY: reverse_q <= byte_val[0];
            `LCD_OP_ALL_LIT: all_lit_q <= byte_val[0];
            `LCD_OP_COM_DIR: com_reverse_q <= byte_val[0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (hw_rst)
         disp_mode_q <= `LCD_MODE_GRAY;
      else if (par_stb && pend_q == P_MODE
               && (byte_val[1:0] == `LCD_MODE_GRAY || byte_val[1:0] == `LCD_MODE_BIN))
         disp_mode_q <= byte_val[1:0];
   end

   // Out-of-range start lines are dropped rather than wrapped
   always_ff @(posedge clock) begin
      if (hw_rst) begin
         start_line_q <= `LCD_START_RST;
      end else if (par_stb && pend_q == P_START_LO && disp_mode_q == `LCD_MODE_GRAY) begin
         if ({1'b0, byte_val} <= `LCD_START_MAX_GRAY)
            start_line_q <= {1'b0, byte_val};
      end else if (par_stb && pend_q == P_START_HI) begin
         if ({byte_val[0], start_lo_q} <= `LCD_START_MAX_BIN)
            start_line_q <= {byte_val[0], start_lo_q};
      end
   end

   always_ff @(posedge clock) begin
      if (hw_rst || soft_rst) begin
         page_q <= `LCD_PAGE_RST;
         column_q <= `LCD_COL_RST;
      end else if (par_stb && pend_q == P_PAGE) begin
         if (byte_val[`LCD_PAGE_W-1:0] <= `LCD_PAGE_MAX)
            page_q <= byte_val[`LCD_PAGE_W-1:0];
      end else if (par_stb && pend_q == P_COLUMN) begin
         if (byte_val <= `LCD_COL_MAX)
            column_q <= byte_val;
      end
   end

   // Notice to the memory side that read-modify-write is cancelled; one cycle on soft reset, held through reset
   always_ff @(posedge clock) begin
      if (hw_rst)
         rmw_clear_q <= 1'b1;
      else
         rmw_clear_q <= soft_rst;
   end

   // ----------------------------------------------------------------------
   // Output drive selection
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (hw_rst)
         drive_q <= lcd_cmd_pkg::DRIVE_GROUND;
      else if (display_on_q)
         drive_q <= lcd_cmd_pkg::DRIVE_NORMAL;
      else if (off_level_mid_q)
         drive_q <= lcd_cmd_pkg::DRIVE_MID;
      else
         drive_q <= lcd_cmd_pkg::DRIVE_GROUND;
   end

endmodule

`default_nettype wire

// file: rtl/lcd_cmd_host.sv
// Purpose: Host end: turns byte requests into 80, 68 or serial bus cycles
// Assumes: Device samples pins through two flip-flops
// Notes:   Each bus phase lasts DIV clocks; serial reads are not possible
`include "lcd_cmd_cfg.svh"
`default_nettype none

module lcd_cmd_host #(
   parameter int DIV = `LCD_HOST_DIV_DEF
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Static bus selection
   input wire lcd_cmd_pkg::bus_mode_t bus_mode,
   // Byte request
   input wire logic req_valid,
   input wire logic req_dsel,
   input wire logic req_read,
   input wire logic [7:0] req_byte,
   output logic req_ready_q,
   // Read answer
   output logic rsp_valid_q,
   output logic [7:0] rsp_byte_q,
   // Bus pins
   lcd_bus_if.host bus
);

   // Phases shorter than four clocks would slip past the driver's synchronisers
   if (DIV < 4 || DIV > 255) begin : g_div_check
      $error("DIV must be 4 to 255");
   end

   typedef enum logic [2:0] {H_IDLE, H_SETUP, H_STROBE, H_HOLD, H_SER_LO, H_SER_HI} hstate_t;

   hstate_t state_q;
   logic [7:0] div_q;
   logic [2:0] bit_q;
   logic read_q;
   logic [7:0] byte_q;
   wire tick = div_q == 8'(DIV - 1);
   wire m68 = bus_mode == lcd_cmd_pkg::BUS_68;

   // ----------------------------------------------------------------------
   // Phase timer, one enable pulse per phase
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst || state_q == H_IDLE || tick)
         div_q <= 8'h00;
      else
         div_q <= div_q + 8'h01;
   end

   // ----------------------------------------------------------------------
   // Sequencer and pins
   // ----------------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q <= H_IDLE;
         req_ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_byte_q <= 8'h00;
         bit_q <= 3'h0;
         read_q <= 1'b0;
         byte_q <= 8'h00;
         bus.hw_reset_n <= 1'b0;
         bus.cmd_data_select <= 1'b0;
         bus.rd_e <= 1'b1;
         bus.wr_rw <= 1'b1;
         bus.host_d <= 8'h00;
         bus.host_d_oe <= 1'b0;
         bus.cs_n <= 1'b1;
         bus.sclk <= 1'b0;
         bus.sdi <= 1'b0;
      end else begin
         bus.hw_reset_n <= 1'b1;
         rsp_valid_q <= 1'b0;
         unique case (state_q)
            H_IDLE: begin
               bus.cs_n <= 1'b1;
               bus.rd_e <= !m68; // Idle strobe level per bus style
               bus.wr_rw <= 1'b1;
               req_ready_q <= 1'b1;
               if (req_valid && req_ready_q) begin
                  req_ready_q <= 1'b0;
                  read_q <= req_read;
                  byte_q <= req_byte;
                  bus.cmd_data_select <= req_dsel;
                  if (bus_mode == lcd_cmd_pkg::BUS_SERIAL) begin
                     // Reads cannot be carried over the serial link; dropped
                     if (!req_read) begin
                        bus.cs_n <= 1'b0;
                        bus.sdi <= req_byte[7];
                        bit_q <= 3'h0;
                        state_q <= H_SER_LO;
                     end
                  end else begin
                     bus.wr_rw <= m68 ? req_read : 1'b1;
                     bus.host_d <= req_byte;
                     bus.host_d_oe <= !req_read;
                     state_q <= H_SETUP;
                  end
               end
            end
            H_SETUP: if (tick) begin
               if (m68)
                  bus.rd_e <= 1'b1;
               else if (read_q)
                  bus.rd_e <= 1'b0;
               else
                  bus.wr_rw <= 1'b0;
               state_q <= H_STROBE;
            end
            H_STROBE: if (tick) begin
               if (read_q) begin
                  rsp_valid_q <= 1'b1;
                  rsp_byte_q <= bus.dev_d;
               end
               bus.rd_e <= !m68;
               bus.wr_rw <= m68 ? read_q : 1'b1;
               state_q <= H_HOLD;
            end
            H_HOLD: if (tick) begin
               bus.host_d_oe <= 1'b0;
               state_q <= H_IDLE;
            end
            H_SER_LO: if (tick) begin
               bus.sclk <= 1'b1;
               state_q <= H_SER_HI;
            end
            H_SER_HI: if (tick) begin
               bus.sclk <= 1'b0;
               bit_q <= bit_q + 3'h1;
               byte_q <= {byte_q[6:0], 1'b0};
               bus.sdi <= byte_q[6];
               state_q <= (bit_q == `LCD_BITS_PER_BYTE) ? H_IDLE : H_SER_LO;
            end
         endcase
      end
   end

endmodule

`default_nettype wire

// file: rtl/lcd_cmd_pkg.sv
// Purpose: Shared types of the LCD command decoder and its host
// Assumes: Nothing
// Notes:   Constants live in lcd_cmd_cfg.svh
`default_nettype none

package lcd_cmd_pkg;
   typedef enum logic [1:0] {BUS_80, BUS_68, BUS_SERIAL} bus_mode_t;
   typedef enum logic [1:0] {XF_COMMAND, XF_PARAM, XF_DATA_READ, XF_DATA_WRITE} xfer_kind_t;
   typedef enum logic [1:0] {DRIVE_NORMAL, DRIVE_GROUND, DRIVE_MID} drive_t;
endpackage

`default_nettype wire

// file: sim/lcd_bus_sva.sv
// Purpose: Wire-level checks between the host and driver ends of the LCD bus
// Assumes: Host built with DIV = 4, so each strobe phase lasts four clocks
// Notes:   Only pins are watched here; settings are judged by the bench
`default_nettype none

module lcd_bus_sva (
   // Clock, reset and bus style
   input wire logic clock,
   input wire logic rst,
   input wire lcd_cmd_pkg::bus_mode_t bus_mode,
   // Bus pins
   input wire logic hw_reset_n,
   input wire logic rd_e,
   input wire logic wr_rw,
   input wire logic [7:0] host_d,
   input wire logic host_d_oe,
   input wire logic dev_d_oe,
   input wire logic cs_n,
   input wire logic sclk
);
   logic [3:0] sclk_rises_q;

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   // Cleared by a high select so an aborted frame cannot leak into the next
   always_ff @(posedge clock) begin
      if (rst || cs_n) begin
         sclk_rises_q <= 4'h0;
      end else if ($rose(sclk)) begin
         sclk_rises_q <= sclk_rises_q + 4'h1;
      end
   end

   // ----------------------------------------------------------------------
   // Pin relations
   // ----------------------------------------------------------------------
   pin_reset_a:
      assert property ($fell(rst) |-> !hw_reset_n ##1 hw_reset_n)
      else $error("pin reset not released after reset");
   no_contention_a:
      assert property (!(host_d_oe && dev_d_oe))
      else $error("both ends drive the data bus");
   read_direction_a:
      assert property (dev_d_oe |-> wr_rw && !host_d_oe)
      else $error("device drives data outside a read");
   write_strobe_a:
      assert property (bus_mode == lcd_cmd_pkg::BUS_80 && $fell(wr_rw)
         |-> (!wr_rw && host_d_oe)[*4] ##1 (wr_rw && host_d_oe))
      else $error("write strobe pulse wrong");
   read_strobe_a:
      assert property (bus_mode == lcd_cmd_pkg::BUS_80 && $fell(rd_e)
         |-> (!rd_e && wr_rw && !host_d_oe)[*4] ##1 rd_e)
      else $error("read strobe pulse wrong");
   enable_pulse_a:
      assert property (bus_mode == lcd_cmd_pkg::BUS_68 && $rose(rd_e) |-> rd_e[*4] ##1 !rd_e)
      else $error("enable pulse wrong");
   direction_set_a:
      assert property (bus_mode == lcd_cmd_pkg::BUS_68 && $rose(rd_e)
         |-> wr_rw != host_d_oe && $stable(wr_rw))
      else $error("direction line not settled at enable");
   data_hold_a:
      assert property (host_d_oe && $past(host_d_oe) |-> $stable(host_d))
      else $error("host data changed while driven");
   serial_bits_a:
      assert property ($rose(cs_n) |-> sclk_rises_q == 4'h8)
      else $error("serial frame not eight clocks");
   serial_idle_a:
      assert property (cs_n |-> !sclk)
      else $error("serial clock moves outside a frame");
endmodule

`default_nettype wire

// file: sim/tb_top.sv
// Purpose: Self-checking bench joining host and driver ends of the LCD bus
// Assumes: Host DIV of 4; memory read data tied to one fixed byte
// Notes:   The command table is replayed once per bus style, each after a reset
`include "lcd_cmd_cfg.svh"
`default_nettype none

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic [7:0] cmd;
      logic [1:0] np;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [3:0] sel;
      logic [8:0] exp;
   } row_t;

   logic clock, rst, req_valid, req_dsel, req_read, req_ready_q, rsp_valid_q, xfer_valid_q;
   logic last_rmw, exp_rmw;
   logic display_on_q, off_level_mid_q, reverse_q, all_lit_q, com_reverse_q, rmw_clear_q;
   logic [7:0] req_byte, rsp_byte_q, xfer_byte_q, last_byte, got, ser_sh, exp_byte;
   logic [1:0] disp_mode_q;
   logic [8:0] start_line_q;
   logic [5:0] page_q;
   logic [7:0] column_q;
   lcd_cmd_pkg::bus_mode_t bus_mode;
   lcd_cmd_pkg::xfer_kind_t xfer_kind_q, last_kind, exp_kind;
   lcd_cmd_pkg::drive_t drive_q;
   int fail_count = 0;
   int n_compared = 0;

   // Select codes: 0 on, 1 off level, 2 reverse, 3 all lit, 4 scan, 5 mode,
   // 6 start line, 7 page, 8 column, 9 drive
   row_t rows [0:22] = '{
      '{8'hAF, 2'h0, 8'h00, 8'h00, 4'h0, 9'h001},
      '{8'hBF, 2'h0, 8'h00, 8'h00, 4'h1, 9'h001},
      '{8'hA7, 2'h0, 8'h00, 8'h00, 4'h2, 9'h001},
      '{8'hA5, 2'h0, 8'h00, 8'h00, 4'h3, 9'h001},
      '{8'hC5, 2'h0, 8'h00, 8'h00, 4'h4, 9'h001},
      '{8'hA6, 2'h0, 8'h00, 8'h00, 4'h2, 9'h000},
      '{8'hA4, 2'h0, 8'h00, 8'h00, 4'h3, 9'h000},
      '{8'hC4, 2'h0, 8'h00, 8'h00, 4'h4, 9'h000},
      '{8'h8A, 2'h1, 8'h83, 8'h00, 4'h6, 9'h083},
      '{8'h8A, 2'h1, 8'h84, 8'h00, 4'h6, 9'h083},
      '{8'hB1, 2'h1, 8'hE0, 8'h00, 4'h7, 9'h020},
      '{8'hB1, 2'h1, 8'h21, 8'h00, 4'h7, 9'h020},
      '{8'h13, 2'h1, 8'h9F, 8'h00, 4'h8, 9'h09F},
      '{8'h13, 2'h1, 8'hA0, 8'h00, 4'h8, 9'h09F},
      '{8'h66, 2'h1, 8'hFD, 8'h00, 4'h5, 9'h001},
      '{8'h8A, 2'h2, 8'h07, 8'hFF, 4'h6, 9'h107},
      '{8'h8A, 2'h2, 8'h08, 8'h01, 4'h6, 9'h107},
      '{8'h8A, 2'h2, 8'h06, 8'hFE, 4'h6, 9'h006},
      '{8'hF0, 2'h0, 8'h00, 8'h00, 4'h8, 9'h09F},
      '{8'hE2, 2'h0, 8'h00, 8'h00, 4'h7, 9'h000},
      '{8'hAE, 2'h0, 8'h00, 8'h00, 4'h9, {7'h00, lcd_cmd_pkg::DRIVE_MID}},
      '{8'hBE, 2'h0, 8'h00, 8'h00, 4'h9, {7'h00, lcd_cmd_pkg::DRIVE_GROUND}},
      '{8'hAF, 2'h0, 8'h00, 8'h00, 4'h9, {7'h00, lcd_cmd_pkg::DRIVE_NORMAL}}
   };

   lcd_bus_if i_lcd_bus_if ();

   lcd_cmd_host #(.DIV(4)) i_lcd_cmd_host (.clock(clock), .rst(rst), .bus_mode(bus_mode),
      .req_valid(req_valid), .req_dsel(req_dsel), .req_read(req_read), .req_byte(req_byte),
      .req_ready_q(req_ready_q), .rsp_valid_q(rsp_valid_q), .rsp_byte_q(rsp_byte_q),
      .bus(i_lcd_bus_if));

   lcd_cmd_device i_lcd_cmd_device (.clock(clock), .rst(rst), .bus(i_lcd_bus_if),
      .bus_mode(bus_mode), .rd_data(8'hC3), .xfer_valid_q(xfer_valid_q),
      .xfer_kind_q(xfer_kind_q), .xfer_byte_q(xfer_byte_q), .display_on_q(display_on_q),
      .off_level_mid_q(off_level_mid_q), .reverse_q(reverse_q), .all_lit_q(all_lit_q),
      .com_reverse_q(com_reverse_q), .disp_mode_q(disp_mode_q), .start_line_q(start_line_q),
      .page_q(page_q), .column_q(column_q), .drive_q(drive_q), .rmw_clear_q(rmw_clear_q));

   lcd_bus_sva i_lcd_bus_sva (.clock(clock), .rst(rst), .bus_mode(bus_mode),
      .hw_reset_n(i_lcd_bus_if.hw_reset_n), .rd_e(i_lcd_bus_if.rd_e),
      .wr_rw(i_lcd_bus_if.wr_rw), .host_d(i_lcd_bus_if.host_d),
      .host_d_oe(i_lcd_bus_if.host_d_oe), .dev_d_oe(i_lcd_bus_if.dev_d_oe),
      .cs_n(i_lcd_bus_if.cs_n), .sclk(i_lcd_bus_if.sclk));

   // ----------------------------------------------------------------------
   // Clock, observers and tasks
   // ----------------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   always @(posedge clock) begin
      if (xfer_valid_q === 1'b1) begin
         last_kind <= xfer_kind_q;
         last_byte <= xfer_byte_q;
         last_rmw <= rmw_clear_q;
      end
   end

   always @(posedge i_lcd_bus_if.sclk) begin
      if (i_lcd_bus_if.cs_n === 1'b0) begin
         ser_sh <= {ser_sh[6:0], i_lcd_bus_if.sdi};
      end
   end

   function automatic logic [8:0] field(input logic [3:0] s);
      case (s)
         4'h0: field = {8'h00, display_on_q};
         4'h1: field = {8'h00, off_level_mid_q};
         4'h2: field = {8'h00, reverse_q};
         4'h3: field = {8'h00, all_lit_q};
         4'h4: field = {8'h00, com_reverse_q};
         4'h5: field = {7'h00, disp_mode_q};
         4'h6: field = start_line_q;
         4'h7: field = {3'h0, page_q};
         4'h9: field = {7'h00, drive_q};
         default: field = {1'b0, column_q};
      endcase
   endfunction

   task automatic print_verdict;
      if (fail_count == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic reset_dut;
      rst = 1'b1;
      repeat (3) @(posedge clock);
      #10;
      `CHK("rmw clear", 1'b1, rmw_clear_q)
      rst = 1'b0;
      repeat (8) @(posedge clock);
      #10;
      `CHK("reset state", ({5'h00, `LCD_MODE_GRAY, `LCD_START_RST, `LCD_PAGE_RST, `LCD_COL_RST,
         lcd_cmd_pkg::DRIVE_GROUND}), ({display_on_q, off_level_mid_q, reverse_q, all_lit_q,
         com_reverse_q, disp_mode_q, start_line_q, page_q, column_q, drive_q}))
   endtask

   // Holds the request until an edge sees ready, then waits out the transfer
   task automatic send(input logic dsel, input logic rd, input logic [7:0] b);
      int n;
      n = 0;
      req_dsel = dsel;
      req_read = rd;
      req_byte = b;
      req_valid = 1'b1;
      do begin @(posedge clock); n++; end while (req_ready_q !== 1'b1 && n < 300);
      #10 req_valid = 1'b0;
      do begin
         @(posedge clock);
         n++;
         if (rsp_valid_q === 1'b1) got = rsp_byte_q;
      end while (req_ready_q !== 1'b1 && n < 600);
      repeat (6) @(posedge clock);
      #10;
      if (bus_mode == lcd_cmd_pkg::BUS_SERIAL && !rd) `CHK("serial bits", b, ser_sh)
   endtask

   initial begin
      // Three passes of about 850, 850 and 2900 clocks, with ample margin
      #3_000_000;
      fail_count++;
      print_verdict();
   end

   initial begin
      rst = 1'b1;
      bus_mode = lcd_cmd_pkg::BUS_80;
      req_valid = 1'b0;
      req_dsel = 1'b0;
      req_read = 1'b0;
      req_byte = 8'h00;
      got = 8'h00;
      for (int m = 0; m < 3; m++) begin
         bus_mode = lcd_cmd_pkg::bus_mode_t'(m);
         reset_dut();
         foreach (rows[i]) begin
            send(1'b0, 1'b0, rows[i].cmd);
            if (rows[i].np != 2'h0) send(1'b1, 1'b0, rows[i].p1);
            if (rows[i].np == 2'h2) send(1'b1, 1'b0, rows[i].p2);
            exp_kind = (rows[i].np == 2'h0) ? lcd_cmd_pkg::XF_COMMAND : lcd_cmd_pkg::XF_PARAM;
            exp_byte = (rows[i].np == 2'h0) ? rows[i].cmd :
               (rows[i].np == 2'h1) ? rows[i].p1 : rows[i].p2;
            `CHK("setting", rows[i].exp, field(rows[i].sel))
            `CHK("transfer", ({exp_kind, exp_byte}), ({last_kind, last_byte}))
            exp_rmw = rows[i].np == 2'h0 && rows[i].cmd == `LCD_CMD_SW_RESET;
            `CHK("soft reset pulse", exp_rmw, last_rmw)
         end
         // A command while a parameter is pending drops that parameter
         send(1'b0, 1'b0, 8'hB1);
         send(1'b0, 1'b0, 8'hAF);
         send(1'b1, 1'b0, 8'h05);
         `CHK("abandoned param", ({lcd_cmd_pkg::XF_DATA_WRITE, 6'h00, 8'h00}),
            ({last_kind, page_q, column_q}))
         got = 8'h00;
         send(1'b1, 1'b1, 8'h00);
         if (bus_mode != lcd_cmd_pkg::BUS_SERIAL) begin
            `CHK("read byte", 8'hC3, got)
            `CHK("read kind", lcd_cmd_pkg::XF_DATA_READ, last_kind)
         end
      end
      print_verdict();
   end
endmodule

`default_nettype wire
